// ### src/tmc_channel.sv
// timer channel: interval timer, square wave output and external event counter
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module tmc_channel
    import tmc_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    input  wire logic [TMC_AW-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output      logic [31:0]         avs_readdata,
    output      logic                avs_waitrequest,
    input  wire logic                sub_clk,
    input  wire logic                event_in,
    output      logic                timer_out,
    output      logic                timer_out_en,
    output      logic                channel_interrupt
);
    import tmc_pkg::*;

    tmc_state_s st_ff;
    tmc_state_s nxt_st;
    tmc_req_s   req;

    function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
        case (sel)
            TMC_EDGE_FALL: edge_hit = prv & ~cur;
            TMC_EDGE_RISE: edge_hit = ~prv & cur;
            TMC_EDGE_BOTH: edge_hit = prv ^ cur;
            default:       edge_hit = 1'b0;
        endcase
    endfunction

    logic [2:0]  op_mode;
    logic        ev_mode;
    logic        tick;
    logic        qtick;
    logic        ev_edge;
    logic        wr_ok;
    logic        acc;
    logic [31:0] ctrl_rd;

    assign req.write     = avs_write;
    assign req.read      = avs_read;
    assign req.address   = avs_address;
    assign req.writedata = avs_writedata;
    assign op_mode = st_ff.mode[TMC_B_MD_LO +: 3];
    assign ev_mode = (op_mode == TMC_MD_EVENT);
    assign ev_edge = edge_hit(st_ff.mode[TMC_B_EDGE_LO +: 2],
                              st_ff.ev_sync, st_ff.ev_prev);
    assign qtick   = st_ff.sub_sync & ~st_ff.sub_prev & (st_ff.qdiv == TMC_QDIV_LAST);
    // count clock: pin edge, fsub/4, or the operating clock otherwise
    assign tick = st_ff.mode[TMC_B_CCS] ? ev_edge
                : st_ff.qsub_sel ? qtick : 1'b1;
    assign acc   = (req.write | req.read) & st_ff.waitreq;
    assign wr_ok = req.write & st_ff.waitreq & st_ff.power;
    assign ctrl_rd = {22'h0, st_ff.pin_en, st_ff.out_mode, st_ff.out_inv, st_ff.out_en,
                      st_ff.out_level, st_ff.qsub_sel, st_ff.active, 2'h0, st_ff.power};

    always_comb begin
        nxt_st = st_ff;
        nxt_st.irq = 1'b0;
        nxt_st.rvalid = 1'b0;
        nxt_st.waitreq = 1'b1;
        // synchronisers for the subclock and the event pin
        nxt_st.sub_meta = sub_clk;
        nxt_st.sub_sync = st_ff.sub_meta;
        nxt_st.sub_prev = st_ff.sub_sync;
        nxt_st.ev_meta  = event_in;
        nxt_st.ev_sync  = st_ff.ev_meta;
        nxt_st.ev_prev  = st_ff.ev_sync;
        if (st_ff.sub_sync & ~st_ff.sub_prev) begin
            nxt_st.qdiv = st_ff.qdiv + 2'h1;
        end
        // counting engine
        if (st_ff.power & st_ff.active) begin
            if (st_ff.start_pend) begin
                if (tick) begin
                    nxt_st.start_pend = 1'b0;
                    nxt_st.count = st_ff.reload;
                    if (st_ff.mode[TMC_B_IRQ_SEL] & ~ev_mode) begin
                        nxt_st.irq = 1'b1;
                        if (st_ff.out_en) begin
                            nxt_st.out_level = ~st_ff.out_level;
                        end
                    end
                end
            end else if (tick) begin
                if (st_ff.count == TMC_COUNT_RST) begin
                    nxt_st.count = st_ff.reload;
                    nxt_st.irq = 1'b1;
                    if (st_ff.out_en & ~ev_mode) begin
                        nxt_st.out_level = ~st_ff.out_level;
                    end
                end else begin
                    nxt_st.count = st_ff.count - 16'h0001;
                end
            end
        end
        // register bus: one wait cycle, then answer
        if (acc) begin
            nxt_st.waitreq = 1'b0;
            nxt_st.rvalid = req.read;
        end
        if (req.read & st_ff.waitreq) begin
            case (req.address)
                TMC_OFS_CTRL:   nxt_st.rdata = ctrl_rd;
                TMC_OFS_MODE:   nxt_st.rdata = {16'h0, st_ff.mode};
                TMC_OFS_RELOAD: nxt_st.rdata = {16'h0, st_ff.reload};
                TMC_OFS_COUNT:  nxt_st.rdata = {16'h0, nxt_st.count};
                default:        nxt_st.rdata = 32'h0;
            endcase
        end
        if (req.write & st_ff.waitreq & (req.address == TMC_OFS_CTRL) & avs_byteenable[0]) begin
            nxt_st.power = req.writedata[TMC_B_POWER];
        end
        if (wr_ok) begin
            case (req.address)
                TMC_OFS_CTRL: begin
                    if (avs_byteenable[0]) begin
                        nxt_st.qsub_sel  = req.writedata[TMC_B_QSUB];
                        nxt_st.out_level = req.writedata[TMC_B_OLVL];
                        nxt_st.out_en    = req.writedata[TMC_B_OEN];
                        nxt_st.out_inv   = req.writedata[TMC_B_OINV];
                        if (req.writedata[TMC_B_START]) begin
                            nxt_st.active = 1'b1;
                            nxt_st.start_pend = 1'b1;
                            if (ev_mode) begin
                                nxt_st.count = st_ff.reload;
                                nxt_st.start_pend = 1'b0;
                            end
                        end
                        if (req.writedata[TMC_B_STOP]) begin
                            nxt_st.active = 1'b0;
                            nxt_st.start_pend = 1'b0;
                            nxt_st.count = st_ff.count;
                        end
                    end
                    if (avs_byteenable[1]) begin
                        nxt_st.out_mode = req.writedata[TMC_B_OMODE];
                        nxt_st.pin_en   = req.writedata[TMC_B_PIN_EN];
                    end
                end
                TMC_OFS_MODE: begin
                    if (avs_byteenable[0]) nxt_st.mode[7:0] = req.writedata[7:0];
                    if (avs_byteenable[1]) nxt_st.mode[15:8] = req.writedata[15:8];
                end
                TMC_OFS_RELOAD: begin
                    if (avs_byteenable[0]) nxt_st.reload[7:0] = req.writedata[7:0];
                    if (avs_byteenable[1]) nxt_st.reload[15:8] = req.writedata[15:8];
                end
                default: ;
            endcase
        end
        // unit power off returns every mapped channel register to reset; the qdiv prescaler keeps running
        if (~nxt_st.power) begin
            nxt_st.active     = 1'b0;
            nxt_st.start_pend = 1'b0;
            nxt_st.qsub_sel   = 1'b0;
            nxt_st.out_level  = 1'b0;
            nxt_st.out_en     = 1'b0;
            nxt_st.out_inv    = 1'b0;
            nxt_st.out_mode   = 1'b0;
            nxt_st.pin_en     = 1'b0;
            nxt_st.mode       = TMC_MODE_RST;
            nxt_st.reload     = TMC_RELOAD_RST;
            nxt_st.count      = TMC_COUNT_RST;
            nxt_st.irq        = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{default: '0, waitreq: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata      = st_ff.rdata;
    assign avs_waitrequest   = st_ff.waitreq;
    assign timer_out         = st_ff.out_level;
    assign timer_out_en      = ~(st_ff.power & st_ff.pin_en);
    assign channel_interrupt = st_ff.irq;

    reload_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & ~st_ff.start_pend & tick & (st_ff.count == 16'h0)
        & ~wr_ok |=> (st_ff.count == $past(st_ff.reload)) & channel_interrupt)
        else $error("counter did not reload at zero");
    count_down_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & ~st_ff.start_pend & tick & (st_ff.count != 16'h0)
        & ~wr_ok |=> st_ff.count == $past(st_ff.count) - 16'h0001)
        else $error("counter did not decrement");
    stop_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ~st_ff.active & ~wr_ok & st_ff.power |=> $stable(st_ff.count) && $stable(timer_out))
        else $error("stopped channel changed");
    power_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ~st_ff.power |-> ~st_ff.active & ~timer_out & (st_ff.count == 16'h0))
        else $error("power off state not reset");
    no_toggle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ~st_ff.out_en & ~wr_ok |=> $stable(timer_out))
        else $error("output toggled while disabled");
    event_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_ok & ev_mode & (req.address == 4'h0) & avs_byteenable[0] & req.writedata[1]
        & ~req.writedata[2] |=> st_ff.active & (st_ff.count == $past(st_ff.reload)))
        else $error("event start did not load");
    event_irq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        channel_interrupt & ev_mode |-> ~$past(st_ff.start_pend))
        else $error("event mode start interrupt");
    // bus handshake steps
    sequence seq_take;
        (avs_read | avs_write) & avs_waitrequest;
    endsequence
    sequence seq_answer;
        ~avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        seq_take |=> seq_answer)
        else $error("bus answer not one cycle");

    logic ctrl_wr;
    assign ctrl_wr = req.write & st_ff.waitreq & (req.address == TMC_OFS_CTRL)
                   & avs_byteenable[0];
    sequence seq_start_wr;
        ctrl_wr & st_ff.power & req.writedata[TMC_B_POWER]
        & req.writedata[TMC_B_START] & ~req.writedata[TMC_B_STOP];
    endsequence

    // triggers and the active flag
    start_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        seq_start_wr
        |=> st_ff.active)
        else $error("start did not set active");
    stop_clear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_wr & st_ff.power & req.writedata[TMC_B_POWER] & req.writedata[TMC_B_STOP]
        |=> ~st_ff.active & (st_ff.count == $past(st_ff.count)))
        else $error("stop did not hold counter");
    trig_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.read & st_ff.waitreq & (req.address == TMC_OFS_CTRL)
        |=> ~avs_readdata[TMC_B_START] & ~avs_readdata[TMC_B_STOP])
        else $error("trigger bit read back set");
    active_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.read & st_ff.waitreq & (req.address == TMC_OFS_CTRL)
        |=> avs_readdata[TMC_B_ACTIVE] == $past(st_ff.active))
        else $error("active flag read wrong");
    irq_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ~st_ff.active
        |=> ~channel_interrupt)
        else $error("interrupt while stopped");

    // interval start and square wave
    interval_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & st_ff.start_pend & tick & ~wr_ok
        |=> (st_ff.count == $past(st_ff.reload)) & ~st_ff.start_pend)
        else $error("first tick did not load");
    start_irq_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & st_ff.start_pend & tick & ~wr_ok & ~ev_mode
        & st_ff.mode[TMC_B_IRQ_SEL] |=> channel_interrupt)
        else $error("no start interrupt");
    start_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & st_ff.start_pend & tick & ~wr_ok
        & ~st_ff.mode[TMC_B_IRQ_SEL] |=> ~channel_interrupt & $stable(timer_out))
        else $error("unwanted start interrupt");
    square_toggle_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & ~st_ff.start_pend & tick & ~wr_ok & ~ev_mode
        & st_ff.out_en & (st_ff.count == TMC_COUNT_RST) |=> timer_out != $past(timer_out))
        else $error("output did not toggle");
    event_quiet_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ev_mode & ~wr_ok
        |=> $stable(timer_out))
        else $error("output moved in event mode");

    // count clock selection and edge detection
    qsub_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & st_ff.qsub_sel & ~st_ff.mode[TMC_B_CCS] & ~qtick
        & ~wr_ok |=> $stable(st_ff.count))
        else $error("counted without quarter tick");
    pin_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_ff.power & st_ff.active & st_ff.mode[TMC_B_CCS] & ~ev_edge & ~wr_ok
        |=> $stable(st_ff.count))
        else $error("counted without pin edge");
    edge_once_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ev_edge & (st_ff.mode[TMC_B_EDGE_LO +: 2] != TMC_EDGE_BOTH) & ~wr_ok
        |=> ~ev_edge)
        else $error("one edge seen twice");

    // power gating and register access
    off_regs_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ~st_ff.power
        |-> (st_ff.mode == TMC_MODE_RST) & (st_ff.reload == TMC_RELOAD_RST)
            & ~st_ff.out_en & timer_out_en)
        else $error("registers kept while off");
    power_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_wr
        |=> st_ff.power == $past(req.writedata[TMC_B_POWER]))
        else $error("power bit not written");
    off_ignore_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ~st_ff.power & req.write & st_ff.waitreq & (req.address == TMC_OFS_RELOAD)
        |=> st_ff.reload == TMC_RELOAD_RST)
        else $error("write taken while off");
    level_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ctrl_wr & st_ff.power & req.writedata[TMC_B_POWER]
        |=> timer_out == $past(req.writedata[TMC_B_OLVL]))
        else $error("output level not applied");
    reload_apply_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_ok & (req.address == TMC_OFS_RELOAD) & avs_byteenable[0] & avs_byteenable[1]
        |=> st_ff.reload == $past(req.writedata[15:0]))
        else $error("reload write lost");
    read_reload_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.read & st_ff.waitreq & (req.address == TMC_OFS_RELOAD)
        |=> avs_readdata == {16'h0, $past(st_ff.reload)})
        else $error("reload read wrong");
    read_mode_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.read & st_ff.waitreq & (req.address == TMC_OFS_MODE)
        |=> avs_readdata == {16'h0, $past(st_ff.mode)})
        else $error("mode read wrong");
    read_count_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.read & st_ff.waitreq & (req.address == TMC_OFS_COUNT) & ~st_ff.active
        |=> avs_readdata == {16'h0, $past(st_ff.count)})
        else $error("stopped count read wrong");
    read_gap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        req.read & st_ff.waitreq & (req.address[1:0] != 2'h0)
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

// ### src/tmc_pkg.sv
// package: register map, field layout and types of the timer channel
package tmc_pkg;
    localparam int          TMC_AW            = 4;
    localparam logic [3:0]  TMC_OFS_CTRL      = 4'h0;
    localparam logic [3:0]  TMC_OFS_MODE      = 4'h4;
    localparam logic [3:0]  TMC_OFS_RELOAD    = 4'h8;
    localparam logic [3:0]  TMC_OFS_COUNT     = 4'hc;
    // ctrl register bit positions
    localparam int          TMC_B_POWER       = 0;
    localparam int          TMC_B_START       = 1;
    localparam int          TMC_B_STOP        = 2;
    localparam int          TMC_B_ACTIVE      = 3;
    localparam int          TMC_B_QSUB        = 4;
    localparam int          TMC_B_OLVL        = 5;
    localparam int          TMC_B_OEN         = 6;
    localparam int          TMC_B_OINV        = 7;
    localparam int          TMC_B_OMODE       = 8;
    localparam int          TMC_B_PIN_EN      = 9;
    // mode register field positions
    localparam int          TMC_B_IRQ_SEL     = 0;
    localparam int          TMC_B_MD_LO       = 1;
    localparam int          TMC_B_EDGE_LO     = 6;
    localparam int          TMC_B_CCS         = 12;
    localparam int          TMC_B_CKS         = 15;
    localparam logic [2:0]  TMC_MD_INTERVAL   = 3'h0;
    localparam logic [2:0]  TMC_MD_EVENT      = 3'h3;
    localparam logic [1:0]  TMC_EDGE_FALL     = 2'h0;
    localparam logic [1:0]  TMC_EDGE_RISE     = 2'h1;
    localparam logic [1:0]  TMC_EDGE_BOTH     = 2'h2;
    localparam logic [15:0] TMC_MODE_RST      = 16'h0000;
    localparam logic [15:0] TMC_RELOAD_RST    = 16'h0000;
    localparam logic [15:0] TMC_COUNT_RST     = 16'h0000;
    localparam logic [1:0]  TMC_QDIV_LAST     = 2'h3;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [3:0]  address;
        logic [31:0] writedata;
    } tmc_req_s;

    typedef struct packed {
        logic        power;
        logic        active;
        logic        start_pend;
        logic        qsub_sel;
        logic        out_level;
        logic        out_en;
        logic        out_inv;
        logic        out_mode;
        logic        pin_en;
        logic [15:0] mode;
        logic [15:0] reload;
        logic [15:0] count;
        logic [1:0]  qdiv;
        logic        sub_meta;
        logic        sub_sync;
        logic        sub_prev;
        logic        ev_meta;
        logic        ev_sync;
        logic        ev_prev;
        logic        irq;
        logic        waitreq;
        logic        rvalid;
        logic [31:0] rdata;
    } tmc_state_s;
endpackage

// ### dv/tmc_pin_model.sv
// far-side pin model: subsystem clock, event pin driver, timer pin watcher
`timescale 1ns/1ps
module tmc_pin_model (
    input  wire logic ref_clk,
    input  wire logic timer_out,
    input  wire logic timer_out_en,
    output      logic sub_clk,
    output      logic event_in,
    output      int   toggles
);
    logic pin;
    // free-running oscillator, 8 ref cycles, phase unrelated
    initial begin
        sub_clk = 1'b0;
        #1;
        forever #16 sub_clk = ~sub_clk;
    end
    initial event_in = 1'b0;
    initial toggles = 0;
    // port side pulls the pin up while the timer function is off
    assign pin = (timer_out_en === 1'b0) ? timer_out : 1'b1;
    always @(pin) toggles = toggles + 1;
    // each level held long enough for the two-stage sampler
    task automatic flip();
        @(posedge ref_clk);
        event_in <= ~event_in;
        repeat (10) @(posedge ref_clk);
    endtask
endmodule

// ### dv/tmc_channel_tb.sv
// self-checking bench of the timer channel
`timescale 1ns/1ps
module tmc_channel_tb;
    import tmc_pkg::*;
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } tmc_row_s;
    logic        ref_clk, arst_n, avs_read, avs_write, sub_clk, event_in;
    logic        timer_out, timer_out_en, channel_interrupt, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd, cnt_q;
    logic        lvl_q;
    int          failures, samples_checked, irq_cnt, gap, last, cyc, toggles, i, t0, q0;
    int          need[3] = '{4, 3, 2};
    tmc_row_s    rows[4] = '{'{4'h8, 32'h1234, 32'h1234}, '{4'h4, 32'h1046, 32'h1046},
                             '{4'h0, 32'h0071, 32'h0071}, '{4'h2, 32'hffff, 32'h0}};
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    tmc_channel u_tmc_channel (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sub_clk(sub_clk), .event_in(event_in),
        .timer_out(timer_out), .timer_out_en(timer_out_en),
        .channel_interrupt(channel_interrupt));
    tmc_pin_model u_tmc_pin_model (.ref_clk(ref_clk), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .sub_clk(sub_clk), .event_in(event_in),
        .toggles(toggles));
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (channel_interrupt === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdr(input logic [3:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq();
        int n;
        n = irq_cnt;
        for (int k = 0; k < 2000 && irq_cnt == n; k++) @(posedge ref_clk);
        if (irq_cnt == n) begin
            failures++;
            finish_test();
        end
    endtask
    initial begin
        arst_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'h3;
        repeat (5) @(posedge ref_clk);
        check(32'({timer_out, timer_out_en, channel_interrupt, avs_waitrequest}), 32'h5);
        arst_n <= 1'b1;
        wr(4'h8, 32'h0055);
        rdr(4'h8);
        check(rd, 32'h0);
        wr(4'h0, 32'h1);
        for (i = 0; i < 4; i++) begin
            wr(rows[i].addr, rows[i].wdata);
            rdr(rows[i].addr);
            check(rd, rows[i].exp);
        end
        wr(4'h4, 32'h1);
        wr(4'h8, 32'h3);
        wr(4'h0, 32'h203);
        wait_irq();
        repeat (2) @(posedge ref_clk);
        t0 = toggles;
        q0 = irq_cnt;
        repeat (40) @(posedge ref_clk);
        check(32'(toggles - t0), 32'h0);
        check(32'(irq_cnt - q0), 32'd10);
        check(32'(gap), 32'd4);
        rdr(4'h0);
        check(rd, 32'h209);
        wr(4'h0, 32'h241);
        wait_irq();
        repeat (2) @(posedge ref_clk);
        t0 = toggles;
        q0 = irq_cnt;
        repeat (40) @(posedge ref_clk);
        check(32'(toggles - t0), 32'(irq_cnt - q0));
        check(32'(timer_out_en), 32'h0);
        wr(4'h0, 32'h245);
        rdr(4'h0);
        check(rd, 32'h241);
        rdr(4'hc);
        cnt_q = rd;
        lvl_q = timer_out;
        repeat (20) @(posedge ref_clk);
        rdr(4'hc);
        check(rd, cnt_q);
        check(32'(timer_out), 32'(lvl_q));
        wr(4'h0, 32'h221);
        t0 = toggles;
        repeat (20) @(posedge ref_clk);
        check(32'(timer_out), 32'h1);
        check(32'(toggles - t0), 32'h0);
        wr(4'h0, 32'h201);
        repeat (2) @(posedge ref_clk);
        check(32'(timer_out), 32'h0);
        wr(4'h4, 32'h0);
        wr(4'h8, 32'h1);
        wr(4'h0, 32'h213);
        wait_irq();
        wait_irq();
        check(32'(gap), 32'd64);
        wr(4'h0, 32'h215);
        for (i = 0; i < 3; i++) begin
            wr(4'h4, 32'h1006 | (32'(i) << 6));
            wr(4'h8, 32'h1);
            wr(4'h0, 32'h203);
            rdr(4'hc);
            check(rd, 32'h1);
            q0 = irq_cnt;
            repeat (need[i] - 1) u_tmc_pin_model.flip();
            check(32'(irq_cnt - q0), 32'h0);
            u_tmc_pin_model.flip();
            check(32'(irq_cnt - q0), 32'h1);
            wr(4'h0, 32'h205);
            if (event_in) u_tmc_pin_model.flip();
        end
        wr(4'h0, 32'h221);
        wr(4'h0, 32'h0);
        repeat (2) @(posedge ref_clk);
        check(32'({timer_out, timer_out_en}), 32'h1);
        for (i = 0; i < 3; i++) begin
            rdr(4'(i * 4));
            check(rd, 32'h0);
        end
        finish_test();
    end
endmodule
